// ---- verilog/epi_core.sv ----
// external pin interrupt logic: two sensed pins, two pin-change groups
// assumes pins are asynchronous, core acknowledges vectors by a pulse
//
// Functional notes
// - two-bit sense: low, any, falling, rising
// - upper group toggle raises group request one
// - lower group toggle raises group request zero
// - pins trigger even when driven as outputs
// - pin-change wake path needs the running clock
// - low level requests while pin stays low
// - edge detection needs the running clock
// - low-level wake path uses synchronised samples
// - vanished wake level gives no request
// - unused upper register bits read zero
// - sense bits 3:2 pin one, 1:0 zero
// - request needs global and pin enable
// - sample pin first; long pulses detected
// - mask bits 1,0 enable own vectors
// - pin flag: set, cleared, zero in level
// - group flag set, cleared, gated by enables
// - per-pin pin-change mask bits
`default_nettype none
module epi_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // pins (asynchronous, pin is readable even when driven as output)
  input  wire logic        ext_irq_pin_zero,
  input  wire logic        ext_irq_pin_one,
  input  wire logic [15:0] pin_change_inputs,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // core side: vector acknowledge pulses, one per source
  input  wire logic [3:0]  irq_ack,
  // requests to core: 0 pin zero, 1 pin one, 2 lower group, 3 upper
  output logic      [3:0]  irq_req,
  output logic             irq,
  // registered wake request for sleep control
  output logic             wake_req
);
  typedef struct packed {
    logic [1:0]  s1_ext;
    logic [1:0]  s2_ext;
    logic [1:0]  prev_ext;
    logic [15:0] s1_pc;
    logic [15:0] s2_pc;
    logic [15:0] prev_pc;
    logic [7:0]  sense;
    logic [1:0]  ext_mask;
    logic [1:0]  ext_flag;
    logic [1:0]  grp_en;
    logic [1:0]  grp_flag;
    logic [7:0]  pc_mask_u;
    logic [7:0]  pc_mask_l;
    logic        global_en;
    logic [7:0]  rdata;
    logic [3:0]  req;
    logic        irq;
    logic        wake;
  } epi_state_t;

  epi_state_t s_q;
  epi_state_t s_d;

  logic [1:0]  ext_hit;
  logic [1:0]  ext_level;
  logic [15:0] pc_tog;
  logic [1:0]  grp_hit;
  logic [1:0]  ext_clr;
  logic [1:0]  grp_clr;

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  // per-pin sense decode on synchronised samples
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ext
      epi_pkg::epi_sense_t md;
      assign md = epi_pkg::epi_sense_t'(s_q.sense[2*g +: 2]);
      always_comb
      begin
        ext_level[g] = (md == epi_pkg::EPI_LOW) && !s_q.s2_ext[g];
        case (md)
          epi_pkg::EPI_ANY:
            ext_hit[g] = s_q.s2_ext[g] ^ s_q.prev_ext[g];
          epi_pkg::EPI_FALL:
            ext_hit[g] = !s_q.s2_ext[g] && s_q.prev_ext[g];
          epi_pkg::EPI_RISE:
            ext_hit[g] = s_q.s2_ext[g] && !s_q.prev_ext[g];
          default:
            ext_hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // per-pin toggle masked, then ORed per group
  assign pc_tog  = (s_q.s2_pc ^ s_q.prev_pc)
                 & {s_q.pc_mask_u, s_q.pc_mask_l};
  assign grp_hit = {|pc_tog[15:8], |pc_tog[7:0]};

  // write-one and vector acknowledge clears
  assign ext_clr = ((reg_wr && reg_addr == epi_pkg::OFS_EXT_FLAG)
                   ? reg_wdata[1:0] : 2'h0) | irq_ack[1:0];
  assign grp_clr = ((reg_wr && reg_addr == epi_pkg::OFS_GRP_FLAG)
                   ? reg_wdata[1:0] : 2'h0) | irq_ack[3:2];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // two-flop synchronisers, then previous sample
    s_d.s1_ext   = {ext_irq_pin_one, ext_irq_pin_zero};
    s_d.s2_ext   = s_q.s1_ext;
    s_d.prev_ext = s_q.s2_ext;
    s_d.s1_pc    = pin_change_inputs;
    s_d.s2_pc    = s_q.s1_pc;
    s_d.prev_pc  = s_q.s2_pc;
    // register writes; unused bits are never stored
    if (reg_wr)
    begin
      case (reg_addr)
        epi_pkg::OFS_SENSE:     s_d.sense = {4'h0, reg_wdata[3:0]};
        epi_pkg::OFS_EXT_MASK:  s_d.ext_mask = reg_wdata[1:0];
        epi_pkg::OFS_GRP_EN:    s_d.grp_en = reg_wdata[1:0];
        epi_pkg::OFS_PC_MASK_U: s_d.pc_mask_u = reg_wdata;
        epi_pkg::OFS_PC_MASK_L: s_d.pc_mask_l = reg_wdata;
        epi_pkg::OFS_GLOBAL:
          s_d.global_en = reg_wdata[epi_pkg::GLOBAL_EN_BIT];
        default: ;
      endcase
    end
    // flags: set wins over clear; level mode holds flag clear
    for (int i = 0; i < 2; i++)
    begin
      if (ext_level[i] || s_q.sense[2*i +: 2] == 2'h0)
        s_d.ext_flag[i] = 1'b0;
      else if (ext_hit[i])
        s_d.ext_flag[i] = 1'b1;
      else if (ext_clr[i])
        s_d.ext_flag[i] = 1'b0;
      if (grp_hit[i])
        s_d.grp_flag[i] = 1'b1;
      else if (grp_clr[i])
        s_d.grp_flag[i] = 1'b0;
    end
    // requests; level request lasts only while the pin is low
    s_d.req[1:0] = (s_d.ext_flag | ext_level) & s_q.ext_mask
                 & {2{s_q.global_en}};
    s_d.req[3:2] = s_d.grp_flag & s_q.grp_en
                 & {2{s_q.global_en}};
    s_d.irq = |s_d.req;
    // reads: data in the cycle after the strobe
    s_d.rdata = epi_pkg::RST_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        epi_pkg::OFS_SENSE:     s_d.rdata = s_q.sense;
        epi_pkg::OFS_EXT_MASK:  s_d.rdata = {6'h0, s_q.ext_mask};
        epi_pkg::OFS_EXT_FLAG:  s_d.rdata = {6'h0, s_q.ext_flag};
        epi_pkg::OFS_GRP_EN:    s_d.rdata = {6'h0, s_q.grp_en};
        epi_pkg::OFS_GRP_FLAG:  s_d.rdata = {6'h0, s_q.grp_flag};
        epi_pkg::OFS_PC_MASK_U: s_d.rdata = s_q.pc_mask_u;
        epi_pkg::OFS_PC_MASK_L: s_d.rdata = s_q.pc_mask_l;
        epi_pkg::OFS_GLOBAL:    s_d.rdata = {s_q.global_en, 7'h00};
        epi_pkg::OFS_PIN_STAT:  s_d.rdata = {6'h0, s_q.s2_ext};
        default:                s_d.rdata = epi_pkg::RST_ZERO;
      endcase
    end
    // wake: low level on an enabled pin, or any masked pin toggle;
    // built from synchronised samples, so it still needs the clock,
    // a clockless wake path belongs to the sleep controller
    s_d.wake = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      if (s_q.ext_mask[i] && s_q.sense[2*i +: 2] == 2'h0)
        s_d.wake = s_d.wake | !s_q.s2_ext[i];
    end
    s_d.wake = s_d.wake | (|pc_tog);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign reg_rdata = s_q.rdata;
  assign irq_req   = s_q.req;
  assign irq       = s_q.irq;
  assign wake_req  = s_q.wake;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_fall;
    @(posedge clk) disable iff (!resetn)
    (s_q.sense[1:0] == 2'h2 && !s_q.s2_ext[0] && s_q.prev_ext[0])
      |=> s_q.ext_flag[0];
  endproperty
  a_fall: assert property (p_fall) else $error("fall missed");

  property p_rise_one;
    @(posedge clk) disable iff (!resetn)
    (s_q.sense[3:2] == 2'h3 && $rose(s_q.s2_ext[1]))
      |=> s_q.ext_flag[1];
  endproperty
  a_rise_one: assert property (p_rise_one) else $error("rise missed");

  property p_upper;
    @(posedge clk) disable iff (!resetn)
    (|((s_q.s2_pc[15:8] ^ s_q.prev_pc[15:8]) & s_q.pc_mask_u))
      |=> s_q.grp_flag[1];
  endproperty
  a_upper: assert property (p_upper) else $error("upper missed");

  property p_lower;
    @(posedge clk) disable iff (!resetn)
    (|((s_q.s2_pc[7:0] ^ s_q.prev_pc[7:0]) & s_q.pc_mask_l))
      |=> s_q.grp_flag[0];
  endproperty
  a_lower: assert property (p_lower) else $error("lower missed");

  property p_level;
    @(posedge clk) disable iff (!resetn)
    (s_q.sense[1:0] == 2'h0 && !s_q.s2_ext[0] && s_q.ext_mask[0]
     && s_q.global_en && $stable(s_q.sense) && $stable(s_q.ext_mask)
     && $stable(s_q.global_en)) |=> irq_req[0];
  endproperty
  a_level: assert property (p_level) else $error("level lost");

  property p_gate;
    @(posedge clk) disable iff (!resetn)
    irq_req[1:0] != 2'h0 |-> $past(s_q.global_en);
  endproperty
  a_gate: assert property (p_gate) else $error("ungated req");

  property p_lvl_flag;
    @(posedge clk) disable iff (!resetn)
    s_q.sense[1:0] == 2'h0 |=> !s_q.ext_flag[0];
  endproperty
  a_lvl_flag: assert property (p_lvl_flag) else $error("flag in lvl");

  property p_rsv;
    @(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == epi_pkg::OFS_SENSE) |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");

  property p_sync;
    @(posedge clk) disable iff (!resetn)
    $changed(pin_change_inputs) ##2 1'b1
      |-> s_q.s2_pc == $past(pin_change_inputs, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth");

  property p_any_zero;
    @(posedge clk) disable iff (!resetn)
    (s_q.sense[1:0] == 2'h1 && (s_q.s2_ext[0] ^ s_q.prev_ext[0]))
      |=> s_q.ext_flag[0];
  endproperty
  a_any_zero: assert property (p_any_zero) else $error("any missed");

  property p_rise_zero;
    @(posedge clk) disable iff (!resetn)
    (s_q.sense[1:0] == 2'h3 && s_q.s2_ext[0] && !s_q.prev_ext[0])
      |=> s_q.ext_flag[0];
  endproperty
  a_rise_zero: assert property (p_rise_zero) else $error("rise missed");

  property p_ext_clr;
    @(posedge clk) disable iff (!resetn)
    (ext_clr[0] && !ext_hit[0]) |=> !s_q.ext_flag[0];
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("flag kept");

  property p_grp_clr;
    @(posedge clk) disable iff (!resetn)
    (grp_clr[1] && !grp_hit[1]) |=> !s_q.grp_flag[1];
  endproperty
  a_grp_clr: assert property (p_grp_clr) else $error("grp kept");

  property p_grp_gate;
    @(posedge clk) disable iff (!resetn)
    irq_req[2] |-> $past(s_q.grp_en[0] && s_q.global_en);
  endproperty
  a_grp_gate: assert property (p_grp_gate) else $error("ungated grp");

  property p_pin_en;
    @(posedge clk) disable iff (!resetn)
    irq_req[1] |-> $past(s_q.ext_mask[1]);
  endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin en");

  property p_wake_lvl;
    @(posedge clk) disable iff (!resetn)
    (s_q.ext_mask[0] && s_q.sense[1:0] == 2'h0 && !s_q.s2_ext[0])
      |=> wake_req;
  endproperty
  a_wake_lvl: assert property (p_wake_lvl) else $error("no lvl wake");

  property p_pc_wake;
    @(posedge clk) disable iff (!resetn)
    (|pc_tog) |=> wake_req;
  endproperty
  a_pc_wake: assert property (p_pc_wake) else $error("no pc wake");

  property p_mask_rsv;
    @(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == epi_pkg::OFS_EXT_MASK)
      |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_mask_rsv: assert property (p_mask_rsv) else $error("mask rsv set");

  property p_lvl_one;
    @(posedge clk) disable iff (!resetn)
    s_q.sense[3:2] == 2'h0 |=> !s_q.ext_flag[1];
  endproperty
  a_lvl_one: assert property (p_lvl_one) else $error("flag1 lvl");

  c_fall:  cover property (@(posedge clk) irq_req[0] && s_q.sense[1:0] == 2'h2);
  c_upper: cover property (@(posedge clk) irq_req[3]);
  c_level: cover property (@(posedge clk) irq_req[1] && s_q.sense[3:2] == 2'h0);
  c_wake:  cover property (@(posedge clk) wake_req);
endmodule
`default_nettype wire

// ---- verilog/epi_pkg.sv ----
// external pin interrupt constants: register map, fields, reset values
// assumes a byte-wide register port on a single 100 MHz clock
`default_nettype none
package epi_pkg;
  // register offsets (byte port, 8-bit address)
  localparam logic [7:0] OFS_SENSE     = 8'h69;
  localparam logic [7:0] OFS_EXT_MASK  = 8'h1d;
  localparam logic [7:0] OFS_EXT_FLAG  = 8'h1c;
  localparam logic [7:0] OFS_GRP_EN    = 8'h68;
  localparam logic [7:0] OFS_GRP_FLAG  = 8'h1b;
  localparam logic [7:0] OFS_PC_MASK_U = 8'h6c;
  localparam logic [7:0] OFS_PC_MASK_L = 8'h6b;
  localparam logic [7:0] OFS_GLOBAL    = 8'h3f;
  localparam logic [7:0] OFS_PIN_STAT  = 8'h70;
  // field positions
  localparam int SENSE_ONE_LSB = 2;
  localparam int SENSE_ZERO_LSB = 0;
  localparam int GLOBAL_EN_BIT = 7;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  // sense modes
  typedef enum logic [1:0] {
    EPI_LOW  = 2'h0,
    EPI_ANY  = 2'h1,
    EPI_FALL = 2'h2,
    EPI_RISE = 2'h3
  } epi_sense_t;
endpackage
`default_nettype wire

// ---- bench/epi_far_side.sv ----
// ---------------------------------------------------------------
// far side: external pin drivers and core handler entry
// ---------------------------------------------------------------
// assumes request and acknowledge bit order of epi_core
`default_nettype none
module epi_far_side (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // wanted pin levels: 17 pin one, 16 pin zero, 15:0 pin change
  input  wire logic [17:0] pin_want,
  output logic      [17:0] pins,
  // core side
  input  wire logic        ack_en,
  input  wire logic        ack_slow,
  input  wire logic [3:0]  irq_req,
  output logic      [3:0]  irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // levels are held for whole cycles, lows until the core acts
  assign pins = pin_want;
  // handler entry a few cycles after a request, lowest source first
  // no re-arm on the edge after an entry: the request drops one later
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_q  <= 4'h0;
      irq_ack <= 4'h0;
    end
    else
    begin
      irq_ack <= 4'h0;
      if (wait_q != 4'h0)
      begin
        wait_q <= wait_q - 4'h1;
        if (wait_q == 4'h1)
          irq_ack <= irq_req & (~irq_req + 4'h1);
      end
      else if (ack_en && irq_req != 4'h0 && irq_ack == 4'h0)
        wait_q <= ack_slow ? 4'h8 : 4'h2;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// ---------------------------------------------------------------
// testbench for the external pin interrupt block
// ---------------------------------------------------------------
// assumes epi_core, epi_pkg and epi_far_side; 100 MHz clock
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, reg_wr, reg_rd, ack_en, ack_slow, irq;
  logic        wake_req;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, m;
  logic [17:0] pin_want, pins;
  logic [3:0]  irq_ack, irq_req, k;
  logic        e;
  int          bad_count, num_checks;
  epi_core DUT (.clk(clk), .resetn(resetn),
    .ext_irq_pin_zero(pins[16]), .ext_irq_pin_one(pins[17]),
    .pin_change_inputs(pins[15:0]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_ack(irq_ack), .irq_req(irq_req),
    .irq(irq), .wake_req(wake_req));
  epi_far_side far (.clk(clk), .resetn(resetn), .pin_want(pin_want),
    .pins(pins), .ack_en(ack_en), .ack_slow(ack_slow),
    .irq_req(irq_req), .irq_ack(irq_ack));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  // far side enters the handler; the request must then drop
  task automatic serve();
    ack_en <= 1'b1;
    ack_slow <= 1'($urandom);
    for (int t = 0; t < 20; t++)
    begin
      @(posedge clk);
      #1;
      if (irq_req == 4'h0)
        break;
    end
    ack_en <= 1'b0;
    chk("irq_req", 8'h00, 8'(irq_req));
  endtask
  // request expected after a fall or a rise in a given sense mode
  function automatic logic exp_req(input logic [1:0] md, input logic f);
    return f ? md != epi_pkg::EPI_RISE :
               (md == epi_pkg::EPI_ANY || md == epi_pkg::EPI_RISE);
  endfunction
  // one sense mode on one pin: fall, then rise
  task automatic sense_case(input int p, input logic [1:0] md);
    wr(epi_pkg::OFS_SENSE, 8'(md) << (2 * p));
    wr(epi_pkg::OFS_EXT_FLAG, 8'h03);
    pin_want[16 + p] <= 1'b0;
    settle();
    e = exp_req(md, 1'b1);
    chk("irq_req", 8'(e) << p, 8'(irq_req));
    chk("irq", 8'(e), 8'(irq));
    chk("wake_req", 8'(md == epi_pkg::EPI_LOW), 8'(wake_req));
    rd(epi_pkg::OFS_EXT_FLAG, 8'(e && md != 2'h0) << p);
    wr(epi_pkg::OFS_EXT_FLAG, 8'h03);
    pin_want[16 + p] <= 1'b1;
    settle();
    chk("irq_req", 8'(exp_req(md, 1'b0)) << p, 8'(irq_req));
  endtask
  initial
  begin
    {reg_wr, reg_rd, ack_en, ack_slow, bad_count, num_checks} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pin_want = 18'h3_0000;
    resetn = 1'b0;
    void'($urandom(14));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(epi_pkg::OFS_EXT_MASK, 8'h00);
    rd(epi_pkg::OFS_PC_MASK_U, 8'h00);
    wr(epi_pkg::OFS_EXT_MASK, 8'hff);
    rd(epi_pkg::OFS_EXT_MASK, 8'h03);
    wr(epi_pkg::OFS_SENSE, 8'hff);
    rd(epi_pkg::OFS_SENSE, 8'h0f);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    wr(epi_pkg::OFS_GLOBAL, 8'h80);
    for (int p = 0; p < 2; p++)
      for (int md = 0; md < 4; md++)
        sense_case(p, 2'(md));
    // global flag withheld: flag set, no request
    wr(epi_pkg::OFS_SENSE, 8'h02);
    wr(epi_pkg::OFS_GLOBAL, 8'h00);
    wr(epi_pkg::OFS_EXT_FLAG, 8'h03);
    pin_want[16] <= 1'b0;
    settle();
    chk("irq_req", 8'h00, 8'(irq_req));
    rd(epi_pkg::OFS_EXT_FLAG, 8'h01);
    wr(epi_pkg::OFS_GLOBAL, 8'h80);
    settle();
    chk("irq_req", 8'h01, 8'(irq_req));
    rd(epi_pkg::OFS_PIN_STAT, 8'h02);
    serve();
    rd(epi_pkg::OFS_EXT_FLAG, 8'h00);
    wr(epi_pkg::OFS_EXT_MASK, 8'h00);
    pin_want[16] <= 1'b1;
    wr(epi_pkg::OFS_GRP_EN, 8'hff);
    rd(epi_pkg::OFS_GRP_EN, 8'h03);
    // random pin toggles through random masks, handler clears
    repeat (12)
    begin
      m = 8'($urandom);
      k = 4'($urandom_range(15, 0));
      wr(k[3] ? epi_pkg::OFS_PC_MASK_U : epi_pkg::OFS_PC_MASK_L, m);
      rd(k[3] ? epi_pkg::OFS_PC_MASK_U : epi_pkg::OFS_PC_MASK_L, m);
      wr(epi_pkg::OFS_GRP_FLAG, 8'h03);
      pin_want[k] <= ~pin_want[k];
      settle();
      e = m[k[2:0]];
      chk("irq_req", 8'(e) << (k[3] ? 3 : 2), 8'(irq_req));
      rd(epi_pkg::OFS_GRP_FLAG, 8'(e) << k[3]);
      serve();
      rd(epi_pkg::OFS_GRP_FLAG, 8'h00);
    end
    tally_and_finish();
  end
  // hang guard
  initial
  begin
    #500us;
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
